/* src/udef_endpoint_flow.sv */
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// - a set stall request answers later IN and OUT tokens without retry with STALL until cleared.
// - writing stall clear drops the stall request; the clear bit always reads zero.
// - each STALL sent sets the stall-sent flag and may raise the endpoint interrupt.
// - packets to a stalling endpoint are dropped; no out-received or rw-allowed set.
// - SETUP on stalled control endpoint is acked, stall flags and in-free cleared.
// - a retry wins over a stall; STALL only without retry.
// - control endpoint always acks SETUP, sets setup-received, never out-received.
// - handover and rw-allowed read zero on the control endpoint.
// - control: clearing setup/out flag frees bank, clearing in-free sends it.
// - control read: first status-stage token gets NAK.
// - status stage seen: CPU data dropped, clearing in-free sends nothing.
// - control OUT retry always acked, sets out-received and in-free.
// - SETUP wins over all, is acked, clears other flags and resets the bank.
// - OUT bank filled sets out-received and handover, interrupt if enabled.
// - clearing handover on OUT frees bank, moves on, flags follow new bank.
// - OUT rw-allowed set while unread bytes remain, cleared when bank empty.
// - byte count of current bank shown; each data read gives next byte.
// - dual OUT banks: next bank already full sets out-received at once.
// - IN bank freed sets in-free and handover together, interrupt if enabled.
// - clearing handover on IN queues bank, moves on, flags follow new bank.
// - IN rw-allowed set while bank has room, cleared when full.
module udef_endpoint_flow (
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// packet engine side, same clock
	input  wire udef_pkg::udef_tok_s     tok,
	input  wire udef_pkg::udef_byte_s    rx,
	input  wire logic                    in_ack,
	output udef_pkg::udef_hs_s           hs,
	output udef_pkg::udef_byte_s         tx,
	// per endpoint interrupt
	output logic [udef_pkg::NUM_EP-1:0]  endpoint_irq
);

	udef_pkg::udef_state_s  s_q, s_d;
	udef_pkg::udef_ep_s     ec;
	logic                   sel_ok, ok, done;
	logic [7:0]             rdv;
	logic [2:0]             si, ti, ri;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic ep_irq(input udef_pkg::udef_ep_s e);
		ep_irq = (e.in_free & e.ien[0]) | (e.stall_sent & e.ien[1]) | (e.out_rx & e.ien[2]) |
			(e.setup_rx & e.ien[3]) | (e.nak_in & e.ien[4]);
	endfunction

	// data port allowed for the given direction on this endpoint
	function automatic logic data_ok(input udef_pkg::udef_ep_s e, input logic ctl, input logic wr);
		if (ctl)
			data_ok = wr ? (e.in_free & ~e.status_seen & (e.ptr < udef_pkg::DEPTH_C))
				: ((e.setup_rx | e.out_rx) & (e.ptr < e.cnt[0]));
		else if (e.dir_in)
			data_ok = wr & ~e.full[e.cur] & (e.ptr < udef_pkg::DEPTH_C);
		else
			data_ok = ~wr & e.full[e.cur] & (e.ptr < e.cnt[e.cur]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state register
	assign prdata       = s_q.prdata;
	assign pready       = s_q.pready;
	assign pslverr      = s_q.pslverr;
	assign hs           = s_q.hs;
	assign tx           = s_q.tx;
	assign endpoint_irq = s_q.irq;

	// selected endpoint view, an out of range select reads as all zero
	assign sel_ok = s_q.sel < 3'(udef_pkg::NUM_EP);
	assign si     = s_q.sel;
	assign ti     = s_q.tx_ep;
	assign ri     = s_q.rx_ep;
	assign ec     = sel_ok ? s_q.ep[si] : '0;
	assign done   = psel & penable & s_q.pready;

	////////////////////////////////////////////////////////////////////////
	// register read mux
	always_comb begin
		rdv = 8'h00;
		ok  = 1'b1;
		unique case (paddr)
			udef_pkg::A_SEL:   rdv = {5'h00, s_q.sel};
			udef_pkg::A_CFG:   rdv = {6'h00, ec.dual, ec.dir_in};
			udef_pkg::A_FLAGS: rdv = {ec.handover & (si != 3'h0), 1'b0,
				data_ok(ec, si == 3'h0, ec.dir_in) & (si != 3'h0), ec.nak_in, ec.setup_rx,
				ec.out_rx, ec.stall_sent, ec.in_free};
			udef_pkg::A_CTRL:  rdv = {5'h00, ec.kill, 1'b0, ec.stall_rq};
			udef_pkg::A_IEN:   rdv = {3'h0, ec.ien};
			udef_pkg::A_COUNT: rdv = {4'h0, ec.cnt[ec.cur]};
			udef_pkg::A_DATA:  rdv = (ec.dir_in || !sel_ok) ? 8'h00 : s_q.mem[si][ec.cur][ec.ptr[2:0]];
			default:           ok  = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state: cpu side first, usb side after so hardware sets win
	always_comb begin
		s_d        = s_q;
		s_d.hs     = '0;
		s_d.tx     = '0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;

		// one wait state keeps prdata registered
		if (psel && penable && !s_q.pready) begin
			s_d.pready  = 1'b1;
			s_d.prdata  = {24'h000000, rdv};
			s_d.pslverr = !ok;
		end

		// write effects and data pops land on the completing edge only
		if (done && ok && pwrite && paddr == udef_pkg::A_SEL)
			s_d.sel = pwdata[2:0];
		if (done && ok && sel_ok) begin
			if (pwrite && paddr == udef_pkg::A_CFG && si != 3'h0) begin
				// reconfiguring restarts the endpoint's banks
				s_d.ep[si].dir_in   = pwdata[udef_pkg::G_DIR_IN];
				s_d.ep[si].dual     = pwdata[udef_pkg::G_DUAL];
				s_d.ep[si].full     = 2'b00;
				s_d.ep[si].cnt      = '0;
				s_d.ep[si].cur      = 1'b0;
				s_d.ep[si].ubank    = 1'b0;
				s_d.ep[si].ptr      = 4'h0;
				s_d.ep[si].out_rx   = 1'b0;
				s_d.ep[si].in_free  = pwdata[udef_pkg::G_DIR_IN];
				s_d.ep[si].handover = pwdata[udef_pkg::G_DIR_IN];
			end
			if (pwrite && paddr == udef_pkg::A_IEN)
				s_d.ep[si].ien = pwdata[4:0];
			if (pwrite && paddr == udef_pkg::A_CTRL) begin
				if (pwdata[udef_pkg::C_STALL_SET])
					s_d.ep[si].stall_rq = 1'b1;
				if (pwdata[udef_pkg::C_STALL_CLR])
					s_d.ep[si].stall_rq = 1'b0;
				if (pwdata[udef_pkg::C_KILL] && s_q.ep[si].dir_in && si != 3'h0)
					s_d.ep[si].kill = 1'b1;
			end
			if (pwrite && paddr == udef_pkg::A_FLAGS) begin
				if (!pwdata[udef_pkg::F_STALL_SENT])
					s_d.ep[si].stall_sent = 1'b0;
				if (!pwdata[udef_pkg::F_NAK_IN])
					s_d.ep[si].nak_in = 1'b0;
				if (si == 3'h0) begin
					// control: flag clear doubles as bank acknowledge
					if (!pwdata[udef_pkg::F_SETUP] && s_q.ep[0].setup_rx) begin
						s_d.ep[0].setup_rx = 1'b0;
						s_d.ep[0].ptr      = 4'h0;
						s_d.ep[0].cnt[0]   = 4'h0;
						s_d.ep[0].in_free  = 1'b1;
					end
					if (!pwdata[udef_pkg::F_OUT] && s_q.ep[0].out_rx) begin
						s_d.ep[0].out_rx = 1'b0;
						s_d.ep[0].ptr    = 4'h0;
						s_d.ep[0].cnt[0] = 4'h0;
					end
					if (!pwdata[udef_pkg::F_IN_FREE] && s_q.ep[0].in_free) begin
						s_d.ep[0].in_free = 1'b0;
						if (!s_q.ep[0].status_seen) begin
							s_d.ep[0].full[0] = 1'b1;
							s_d.ep[0].cnt[0]  = s_q.ep[0].ptr;
							s_d.ep[0].ptr     = 4'h0;
						end
					end
				end else begin
					if (!pwdata[udef_pkg::F_OUT])
						s_d.ep[si].out_rx = 1'b0;
					if (!pwdata[udef_pkg::F_IN_FREE])
						s_d.ep[si].in_free = 1'b0;
					// handover clear: sets the transfer flag from the next bank, whatever firmware wrote to it
					if (!pwdata[udef_pkg::F_HANDOVER] && s_q.ep[si].handover) begin
						s_d.ep[si].handover = 1'b0;
						s_d.ep[si].ptr      = 4'h0;
						s_d.ep[si].cur      = s_q.ep[si].cur ^ s_q.ep[si].dual;
						if (s_q.ep[si].dir_in) begin
							s_d.ep[si].full[s_q.ep[si].cur] = 1'b1;
							s_d.ep[si].last = s_q.ep[si].cur;
							s_d.ep[si].in_free  = !s_d.ep[si].full[s_d.ep[si].cur];
							s_d.ep[si].handover = !s_d.ep[si].full[s_d.ep[si].cur];
						end else begin
							s_d.ep[si].full[s_q.ep[si].cur] = 1'b0;
							s_d.ep[si].out_rx   = s_d.ep[si].full[s_d.ep[si].cur];
							s_d.ep[si].handover = s_d.ep[si].full[s_d.ep[si].cur];
						end
					end
				end
			end
			// data port: reads pop, writes push, refused beyond the bank
			if (paddr == udef_pkg::A_DATA && data_ok(s_q.ep[si], si == 3'h0, pwrite)) begin
				if (pwrite) begin
					s_d.mem[si][s_q.ep[si].cur][s_q.ep[si].ptr[2:0]] = pwdata[7:0];
					s_d.ep[si].cnt[s_q.ep[si].cur] = s_q.ep[si].ptr + 4'h1;
				end
				s_d.ep[si].ptr = s_q.ep[si].ptr + 4'h1;
			end
		end

		// kill waits while its bank is on the wire, so a packet is never cut short
		for (int k = 1; k < udef_pkg::NUM_EP; k++) begin
			if (s_q.ep[k].kill && !((s_q.tx_busy || s_q.ack_wait) && s_q.tx_ep == 3'(k)
					&& s_q.tx_bank == s_q.ep[k].last)) begin
				s_d.ep[k].kill = 1'b0;
				if (s_q.ep[k].full[s_q.ep[k].last]) begin
					s_d.ep[k].full[s_q.ep[k].last] = 1'b0;
					s_d.ep[k].cnt[s_q.ep[k].last]  = 4'h0;
					s_d.ep[k].cur      = s_q.ep[k].last;
					s_d.ep[k].ubank    = s_q.ep[k].last ^ s_q.ep[k].full[~s_q.ep[k].last];
					s_d.ep[k].ptr      = 4'h0;
					s_d.ep[k].in_free  = 1'b1;
					s_d.ep[k].handover = 1'b1;
				end
			end
		end

		// in data streaming, one byte a cycle
		if (s_q.tx_busy) begin
			s_d.tx.valid = 1'b1;
			s_d.tx.data  = s_q.mem[ti][s_q.tx_bank][s_q.tx_ptr[2:0]];
			s_d.tx.last  = (s_q.tx_ptr + 4'h1) == s_q.tx_cnt;
			s_d.tx_ptr   = s_q.tx_ptr + 4'h1;
			if (s_d.tx.last) begin
				s_d.tx_busy  = 1'b0;
				s_d.ack_wait = 1'b1;
			end
		end

		// host acknowledged the data packet: bank free again
		if (in_ack && s_q.ack_wait) begin
			s_d.ack_wait = 1'b0;
			if (ti == 3'h0) begin
				s_d.ep[0].full[0] = 1'b0;
				s_d.ep[0].ptr     = 4'h0;
				s_d.ep[0].cnt[0]  = 4'h0;
				if (!s_q.ep[0].status_seen)
					s_d.ep[0].in_free = 1'b1;
			end else begin
				s_d.ep[ti].full[s_q.tx_bank] = 1'b0;
				// stale count would make a later empty handover resend old bytes
				s_d.ep[ti].cnt[s_q.tx_bank]  = 4'h0;
				s_d.ep[ti].ubank = s_q.tx_bank ^ s_q.ep[ti].dual;
				if (s_q.tx_bank == s_d.ep[ti].cur) begin
					s_d.ep[ti].in_free  = 1'b1;
					s_d.ep[ti].handover = 1'b1;
					s_d.ep[ti].ptr      = 4'h0;
				end
			end
		end

		// packet bytes from host
		if (rx.valid && s_q.rx_mode == udef_pkg::RX_STORE && s_q.rx_ptr < udef_pkg::DEPTH_C) begin
			s_d.mem[ri][s_q.rx_bank][s_q.rx_ptr[2:0]] = rx.data;
			s_d.rx_ptr = s_q.rx_ptr + 4'h1;
		end
		if (rx.last && s_q.rx_mode != udef_pkg::RX_IDLE) begin
			s_d.rx_mode  = udef_pkg::RX_IDLE;
			s_d.hs.valid = s_q.rx_hs != udef_pkg::HS_NONE;
			s_d.hs.code  = s_q.rx_hs;
			s_d.hs.ep    = ri;
			if (s_q.rx_hs == udef_pkg::HS_STALL)
				s_d.ep[ri].stall_sent = 1'b1;
			if (s_q.rx_mode == udef_pkg::RX_STORE) begin
				s_d.ep[ri].cnt[s_q.rx_bank] = s_d.rx_ptr;
				if (ri == 3'h0) begin
					s_d.ep[0].ptr      = 4'h0;
					s_d.ep[0].setup_rx = s_q.rx_setup;
					s_d.ep[0].out_rx   = !s_q.rx_setup;
				end else begin
					s_d.ep[ri].full[s_q.rx_bank] = 1'b1;
					s_d.ep[ri].ubank = s_q.rx_bank ^ s_q.ep[ri].dual;
					if (s_q.rx_bank == s_d.ep[ri].cur) begin
						s_d.ep[ri].out_rx   = 1'b1;
						s_d.ep[ri].handover = 1'b1;
						s_d.ep[ri].ptr      = 4'h0;
					end
				end
			end
		end

		// token decode: decides handshake, bank and drop
		if (tok.valid && tok.ep < 3'(udef_pkg::NUM_EP)) begin
			s_d.rx_ep    = tok.ep;
			s_d.rx_ptr   = 4'h0;
			s_d.rx_setup = 1'b0;
			s_d.rx_mode  = udef_pkg::RX_DROP;
			s_d.rx_hs    = udef_pkg::HS_NONE;
			unique case (tok.pid)
				udef_pkg::PID_SETUP: begin
					if (tok.ep == 3'h0) begin
						// setup overrides everything on the control endpoint
						s_d.ep[0].stall_rq    = 1'b0;
						s_d.ep[0].stall_sent  = 1'b0;
						s_d.ep[0].in_free     = 1'b0;
						s_d.ep[0].out_rx      = 1'b0;
						s_d.ep[0].setup_rx    = 1'b0;
						s_d.ep[0].nak_in      = 1'b0;
						s_d.ep[0].full        = 2'b00;
						s_d.ep[0].cnt         = '0;
						s_d.ep[0].ptr         = 4'h0;
						s_d.ep[0].ctl_read    = 1'b0;
						s_d.ep[0].status_seen = 1'b0;
						s_d.rx_mode  = udef_pkg::RX_STORE;
						s_d.rx_setup = 1'b1;
						s_d.rx_bank  = 1'b0;
						s_d.rx_hs    = udef_pkg::HS_ACK;
					end
				end
				udef_pkg::PID_OUT: begin
					if (tok.retry) begin
						s_d.rx_hs = udef_pkg::HS_ACK;
						if (tok.ep == 3'h0) begin
							s_d.ep[0].out_rx  = 1'b1;
							s_d.ep[0].in_free = 1'b1;
						end
					end else if (s_q.ep[tok.ep].stall_rq)
						s_d.rx_hs = udef_pkg::HS_STALL;
					else if (tok.ep == 3'h0) begin
						if (s_q.ep[0].ctl_read && !s_q.ep[0].status_seen) begin
							s_d.rx_hs = udef_pkg::HS_NAK;
							s_d.ep[0].status_seen = 1'b1;
							s_d.ep[0].full        = 2'b00;
							s_d.ep[0].ptr         = 4'h0;
							s_d.ep[0].cnt         = '0;
						end else if (s_q.ep[0].out_rx || s_q.ep[0].setup_rx)
							s_d.rx_hs = udef_pkg::HS_NAK;
						else begin
							s_d.rx_mode = udef_pkg::RX_STORE;
							s_d.rx_bank = 1'b0;
							s_d.rx_hs   = udef_pkg::HS_ACK;
						end
					end else if (!s_q.ep[tok.ep].dir_in) begin
						if (s_q.ep[tok.ep].full[s_q.ep[tok.ep].ubank])
							s_d.rx_hs = udef_pkg::HS_NAK;
						else begin
							s_d.rx_mode = udef_pkg::RX_STORE;
							s_d.rx_bank = s_q.ep[tok.ep].ubank;
							s_d.rx_hs   = udef_pkg::HS_ACK;
						end
					end
				end
				udef_pkg::PID_IN: begin
					s_d.rx_mode  = udef_pkg::RX_IDLE;
					s_d.hs.ep    = tok.ep;
					s_d.hs.valid = (tok.ep == 3'h0) || s_q.ep[tok.ep].dir_in || s_q.ep[tok.ep].stall_rq;
					if (s_q.ep[tok.ep].stall_rq && !tok.retry) begin
						s_d.hs.code = udef_pkg::HS_STALL;
						s_d.ep[tok.ep].stall_sent = 1'b1;
					end else if (s_q.ep[tok.ep].full[s_q.ep[tok.ep].ubank] && !s_q.tx_busy
							&& !s_q.ack_wait) begin
						s_d.hs.code  = udef_pkg::HS_DATA;
						s_d.tx_ep    = tok.ep;
						s_d.tx_bank  = s_q.ep[tok.ep].ubank;
						s_d.tx_ptr   = 4'h0;
						s_d.tx_cnt   = s_q.ep[tok.ep].cnt[s_q.ep[tok.ep].ubank];
						s_d.tx_busy  = s_d.tx_cnt != 4'h0;
						s_d.ack_wait = s_d.tx_cnt == 4'h0;
						if (tok.ep == 3'h0)
							s_d.ep[0].ctl_read = 1'b1;
					end else begin
						s_d.hs.code = udef_pkg::HS_NAK;
						s_d.ep[tok.ep].nak_in = s_d.hs.valid;
					end
				end
			endcase
		end

		for (int k = 0; k < udef_pkg::NUM_EP; k++)
			s_d.irq[k] = ep_irq(s_d.ep[k]);
	end

	////////////////////////////////////////////////////////////////////////
	// state register, everything resets to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q     <= '0;
			s_q.sel <= udef_pkg::RST_SEL;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_stall_tok;
		tok.valid && tok.ep != 3'h0 && tok.ep < 3'h7 && tok.pid == udef_pkg::PID_IN &&
			!tok.retry && s_q.ep[tok.ep].stall_rq;
	endsequence

	sequence seq_setup_tok;
		tok.valid && tok.ep == 3'h0 && tok.pid == udef_pkg::PID_SETUP;
	endsequence

	chk_stall_in_answer: assert property (seq_stall_tok |=> hs.valid && hs.code == udef_pkg::HS_STALL)
		else $error("stalled endpoint did not answer STALL");

	chk_stall_clear_bit: assert property (done && pwrite && paddr == udef_pkg::A_CTRL && sel_ok &&
			pwdata[udef_pkg::C_STALL_CLR] |=> !s_q.ep[si].stall_rq && s_q.prdata[1] == 1'b0)
		else $error("stall clear did not drop the stall request");

	chk_stall_sent_flag: assert property (hs.valid && hs.code == udef_pkg::HS_STALL |->
			s_q.ep[hs.ep].stall_sent)
		else $error("STALL sent without stall-sent flag");

	chk_stall_no_store: assert property (tok.valid && tok.pid == udef_pkg::PID_OUT && !tok.retry &&
			tok.ep < 3'h7 && s_q.ep[tok.ep].stall_rq |=> s_q.rx_mode == udef_pkg::RX_DROP)
		else $error("stalled packet not dropped");

	chk_setup_clears: assert property (seq_setup_tok |=> !s_q.ep[0].stall_rq && !s_q.ep[0].stall_sent &&
			!s_q.ep[0].in_free && s_q.rx_hs == udef_pkg::HS_ACK ##0 s_q.ep[0].cnt == '0)
		else $error("setup did not clear the control endpoint");

	chk_retry_wins: assert property (tok.valid && tok.pid == udef_pkg::PID_OUT && tok.retry &&
			tok.ep < 3'h7 |=> s_q.rx_hs == udef_pkg::HS_ACK)
		else $error("retry not acknowledged");

	chk_ctrl_bits_zero: assert property (psel && penable && !s_q.pready && paddr == udef_pkg::A_FLAGS &&
			s_q.sel == 3'h0 |=> prdata[7] == 1'b0 && prdata[5] == 1'b0)
		else $error("control endpoint shows handover or rw-allowed");

	chk_status_nak: assert property (tok.valid && tok.ep == 3'h0 && tok.pid == udef_pkg::PID_OUT && !tok.retry &&
			!s_q.ep[0].stall_rq && s_q.ep[0].ctl_read && !s_q.ep[0].status_seen |=>
			s_q.rx_hs == udef_pkg::HS_NAK && s_q.ep[0].status_seen && s_q.ep[0].full == 2'b00)
		else $error("first status token not NAKed");

	chk_out_fill_flags: assert property (rx.last && s_q.rx_mode == udef_pkg::RX_STORE && s_q.rx_ep != 3'h0 &&
			s_q.rx_bank == s_q.ep[s_q.rx_ep].cur |=> s_q.ep[$past(s_q.rx_ep)].out_rx &&
			s_q.ep[$past(s_q.rx_ep)].handover)
		else $error("filled OUT bank did not raise flags");

endmodule

/* src/udef_pkg.sv */
package udef_pkg;

	// endpoint and bank geometry
	localparam int          NUM_EP  = 7;
	localparam int          DEPTH   = 8;
	localparam logic [3:0]  DEPTH_C = 4'h8;

	// apb register byte addresses, endpoint registers act on the selected endpoint
	localparam logic [7:0]  A_SEL   = 8'h00;
	localparam logic [7:0]  A_CFG   = 8'h04;
	localparam logic [7:0]  A_FLAGS = 8'h08;
	localparam logic [7:0]  A_CTRL  = 8'h0C;
	localparam logic [7:0]  A_IEN   = 8'h10;
	localparam logic [7:0]  A_COUNT = 8'h14;
	localparam logic [7:0]  A_DATA  = 8'h18;

	// flag register bit positions (write zero clears, except the read-only rw-allowed bit)
	localparam int          F_IN_FREE    = 0;
	localparam int          F_STALL_SENT = 1;
	localparam int          F_OUT        = 2;
	localparam int          F_SETUP      = 3;
	localparam int          F_NAK_IN     = 4;
	localparam int          F_BANK_RW_ALLOWED       = 5;
	localparam int          F_HANDOVER   = 7;

	// control register bits (write one acts)
	localparam int          C_STALL_SET = 0;
	localparam int          C_STALL_CLR = 1;
	localparam int          C_KILL      = 2;

	// configuration register bits
	localparam int          G_DIR_IN = 0;
	localparam int          G_DUAL   = 1;

	// values after reset
	localparam logic [4:0]  RST_IEN = 5'h00;
	localparam logic [2:0]  RST_SEL = 3'h0;

	typedef enum logic [1:0] {PID_SETUP = 2'b00, PID_OUT = 2'b01, PID_IN = 2'b10} udef_pid_e;
	typedef enum logic [2:0] {HS_NONE = 3'b000, HS_ACK = 3'b001, HS_NAK = 3'b010,
		HS_STALL = 3'b011, HS_DATA = 3'b100} udef_hs_e;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_DROP = 2'b01, RX_STORE = 2'b10} udef_rx_e;

	typedef struct packed {logic valid; udef_pid_e pid; logic [2:0] ep; logic retry;} udef_tok_s;
	typedef struct packed {logic valid; logic [7:0] data; logic last;} udef_byte_s;
	typedef struct packed {logic valid; udef_hs_e code; logic [2:0] ep;} udef_hs_s;

	typedef struct packed {
		logic            dir_in, dual, stall_rq, stall_sent, out_rx, setup_rx, in_free, nak_in;
		logic            handover, kill, ctl_read, status_seen;
		logic [4:0]      ien;
		logic [1:0]      full;
		logic [1:0][3:0] cnt;
		logic            cur, ubank, last;
		logic [3:0]      ptr;
	} udef_ep_s;

	typedef struct packed {
		logic [2:0]                               sel;
		udef_ep_s [NUM_EP-1:0]                    ep;
		logic [NUM_EP-1:0][1:0][DEPTH-1:0][7:0]   mem;
		udef_rx_e                                 rx_mode;
		logic [2:0]                               rx_ep;
		logic                                     rx_bank, rx_setup;
		logic [3:0]                               rx_ptr;
		udef_hs_e                                 rx_hs;
		logic                                     tx_busy, tx_bank, ack_wait;
		logic [2:0]                               tx_ep;
		logic [3:0]                               tx_ptr, tx_cnt;
		udef_hs_s                                 hs;
		udef_byte_s                               tx;
		logic [NUM_EP-1:0]                        irq;
		logic                                     pready, pslverr;
		logic [31:0]                              prdata;
	} udef_state_s;

endpackage

/* sim/udef_host_model.sv */
`timescale 1ns/10ps
module udef_host_model (
	// clock
	input  wire logic                pclk,
	// device answer
	input  wire udef_pkg::udef_hs_s  hs,
	input  wire udef_pkg::udef_byte_s  tx,
	// host requests
	output udef_pkg::udef_tok_s      tok,
	output udef_pkg::udef_byte_s     rx,
	output logic                     in_ack
);
	udef_pkg::udef_hs_s last_hs;
	int                 nrx;
	logic [7:0]         got [8];
	initial begin
		nrx = 0;
		tok = '0;
		rx = '0;
		in_ack = 1'b0;
		last_hs = '0;
	end
	// keep the latest handshake, it stands one cycle only
	always @(posedge pclk) begin
		if (hs.valid) begin
			last_hs <= hs;
		end
	end
	// collect in data bytes, at most one bank
	always @(posedge pclk) begin
		if (tx.valid && nrx < 8) begin
			got[nrx] <= tx.data;
			nrx <= nrx + 1;
		end
	end
	// in token, collect the data, then acknowledge it; a zero length packet waits out the bound
	task automatic fetch(input logic [2:0] ep);
		int k;
		@(posedge pclk);
		last_hs <= '0;
		nrx <= 0;
		tok <= '{1'b1, udef_pkg::PID_IN, ep, 1'b0};
		@(posedge pclk);
		tok <= '0;
		@(posedge pclk);
		if (hs.valid && hs.code == udef_pkg::HS_DATA) begin
			for (k = 0; k < 9 && !(tx.valid && tx.last); k++) @(posedge pclk);
			in_ack <= 1'b1;
			@(posedge pclk);
			in_ack <= 1'b0;
		end
		repeat (2) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////
	// token, then n bytes one a cycle; zero bytes sends a bare end marker
	task automatic send(input udef_pkg::udef_pid_e pid, input logic [2:0] ep, input int n);
		@(posedge pclk);
		last_hs <= '0;
		tok <= '{1'b1, pid, ep, 1'b0};
		@(posedge pclk);
		tok <= '0;
		for (int i = 0; i < n; i++) begin
			rx <= '{1'b1, 8'hA0 + 8'(i), i == n - 1};
			@(posedge pclk);
		end
		if (n == 0) begin
			rx <= '{1'b0, 8'h5A, 1'b1};
			@(posedge pclk);
		end
		// released line flips its data so a stale byte never looks fresh
		rx <= '{1'b0, ~rx.data, 1'b0};
		repeat (2) @(posedge pclk);
	endtask
endmodule

/* sim/usb_device_endpoint_flow_tb_top.sv */
`timescale 1ns/10ps
module usb_device_endpoint_flow_tb_top;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} udef_row_s;
	logic                  pclk = 1'b0;
	logic                  presetn, psel, penable, pwrite, pready, pslverr, in_ack, er;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, rd;
	udef_pkg::udef_tok_s   tok;
	udef_pkg::udef_byte_s  rx, tx;
	udef_pkg::udef_hs_s    hs;
	logic [6:0]            endpoint_irq;
	int                    num_errors = 0;
	int                    compares = 0;
	udef_row_s rows [5] = '{'{udef_pkg::A_IEN, 32'h1F, 32'h1F, 1'b0}, '{udef_pkg::A_CTRL, 32'h1, 32'h1, 1'b0},
		'{udef_pkg::A_CTRL, 32'h2, 32'h0, 1'b0}, '{8'h1C, 32'hFF, 32'h0, 1'b1}, '{udef_pkg::A_SEL, 32'h1, 32'h1, 1'b0}};
	always #2 pclk = ~pclk;
	udef_endpoint_flow udef_endpoint_flow_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tok(tok), .rx(rx), .in_ack(in_ack), .hs(hs), .tx(tx), .endpoint_irq(endpoint_irq));
	udef_host_model udef_host_model_inst (.pclk(pclk), .hs(hs), .tx(tx), .tok(tok), .rx(rx), .in_ack(in_ack));
	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; pready is sampled at rising edges, request held until then
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			num_errors++;
			final_report();
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].exp);
			chk({31'h0, er}, {31'h0, rows[i].err});
		end
		// ep1 plain out packet, then drained by the cpu
		apb(1'b1, udef_pkg::A_IEN, 32'h04);
		udef_host_model_inst.send(udef_pkg::PID_OUT, 3'h1, 3);
		chk(32'(udef_host_model_inst.last_hs.code), 32'(udef_pkg::HS_ACK));
		chk({31'h0, endpoint_irq[1]}, 32'h1);
		rc(udef_pkg::A_FLAGS, 32'hA4);
		rc(udef_pkg::A_COUNT, 32'h3);
		for (int i = 0; i < 3; i++) begin
			rc(udef_pkg::A_DATA, 32'hA0 + 32'(i));
		end
		rc(udef_pkg::A_FLAGS, 32'h84);
		apb(1'b1, udef_pkg::A_FLAGS, 32'h80);
		apb(1'b1, udef_pkg::A_FLAGS, 32'h00);
		rc(udef_pkg::A_FLAGS, 32'h00);
		// stalled ep1 keeps stalling and drops the data
		apb(1'b1, udef_pkg::A_CTRL, 32'h1);
		repeat (2) begin
			udef_host_model_inst.send(udef_pkg::PID_OUT, 3'h1, 2);
			chk(32'(udef_host_model_inst.last_hs.code), 32'(udef_pkg::HS_STALL));
		end
		rc(udef_pkg::A_FLAGS, 32'h02);
		apb(1'b1, udef_pkg::A_CTRL, 32'h2);
		// setup on stalled control endpoint wins
		apb(1'b1, udef_pkg::A_SEL, 32'h0);
		apb(1'b1, udef_pkg::A_CTRL, 32'h1);
		udef_host_model_inst.send(udef_pkg::PID_SETUP, 3'h0, 8);
		chk(32'(udef_host_model_inst.last_hs.code), 32'(udef_pkg::HS_ACK));
		rc(udef_pkg::A_FLAGS, 32'h08);
		rc(udef_pkg::A_CTRL, 32'h0);
		// control read: one byte out, then status stage drops cpu data
		apb(1'b1, udef_pkg::A_FLAGS, 32'h00);
		apb(1'b1, udef_pkg::A_DATA, 32'h44);
		apb(1'b1, udef_pkg::A_FLAGS, 32'h00);
		udef_host_model_inst.fetch(3'h0);
		chk({24'h0, udef_host_model_inst.got[0]}, 32'h44);
		udef_host_model_inst.send(udef_pkg::PID_OUT, 3'h0, 0);
		chk(32'(udef_host_model_inst.last_hs.code), 32'(udef_pkg::HS_NAK));
		apb(1'b1, udef_pkg::A_DATA, 32'h55);
		apb(1'b1, udef_pkg::A_FLAGS, 32'h00);
		udef_host_model_inst.fetch(3'h0);
		chk(32'(udef_host_model_inst.last_hs.code), 32'(udef_pkg::HS_NAK));
		chk(32'(udef_host_model_inst.nrx), 32'h0);
		// ep2 dual bank in: hand over, send, then kill the next bank
		apb(1'b1, udef_pkg::A_SEL, 32'h2);
		apb(1'b1, udef_pkg::A_CFG, 32'h3);
		rc(udef_pkg::A_FLAGS, 32'hA1);
		apb(1'b1, udef_pkg::A_DATA, 32'h11);
		apb(1'b1, udef_pkg::A_DATA, 32'h22);
		apb(1'b1, udef_pkg::A_FLAGS, 32'h80);
		apb(1'b1, udef_pkg::A_FLAGS, 32'h00);
		rc(udef_pkg::A_FLAGS, 32'hA1);
		udef_host_model_inst.fetch(3'h2);
		chk(32'(udef_host_model_inst.nrx), 32'h2);
		chk({24'h0, udef_host_model_inst.got[1]}, 32'h22);
		apb(1'b1, udef_pkg::A_DATA, 32'h33);
		apb(1'b1, udef_pkg::A_FLAGS, 32'h80);
		apb(1'b1, udef_pkg::A_FLAGS, 32'h00);
		apb(1'b1, udef_pkg::A_CTRL, 32'h4);
		rc(udef_pkg::A_CTRL, 32'h0);
		udef_host_model_inst.fetch(3'h2);
		chk(32'(udef_host_model_inst.last_hs.code), 32'(udef_pkg::HS_NAK));
		// second reset mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rc(udef_pkg::A_IEN, 32'h0);
		final_report();
	end
endmodule
